/* File: verilog/uxc_pkg.sv */
// constants and types shared by both ends of the usb transceiver control link
package uxc_pkg;
    // ****************************************************************
    // register offsets on the special function register link
    // ****************************************************************
    localparam logic [7:0] UXC_XCVR_OFS   = 8'hd7;
    localparam logic [7:0] UXC_ADR_OFS    = 8'h96;
    localparam logic [7:0] UXC_DAT_OFS    = 8'h97;
    // core register addresses
    localparam logic [5:0] UXC_INDEX_ADDR = 6'h0f;
    localparam logic [5:0] UXC_IDX_LO     = 6'h10;
    localparam logic [5:0] UXC_IDX_HI     = 6'h17;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int UXC_PULLUP_ENABLE_BIT   = 7;
    localparam int UXC_PHY_ENABLE_BIT  = 6;
    localparam int UXC_SPEED_BIT  = 5;
    localparam int UXC_TST_HI_BIT = 4;
    localparam int UXC_TST_LO_BIT = 3;
    localparam int UXC_DIFF_BIT   = 2;
    localparam int UXC_DP_BIT     = 1;
    localparam int UXC_DN_BIT     = 0;
    localparam int UXC_BUSY_BIT   = 7;
    localparam int UXC_AUTO_BIT   = 6;
    // ****************************************************************
    // reset values and timing
    // ****************************************************************
    localparam logic [7:0] UXC_XCVR_RST  = 8'h00;
    localparam logic [7:0] UXC_DAT_RST   = 8'h00;
    localparam logic [5:0] UXC_ADDR_RST  = 6'h00;
    localparam logic [3:0] UXC_INDEX_RST = 4'h0;
    localparam logic [1:0] UXC_READ_LAT  = 2'h2;
    // endpoint protocol addresses
    localparam logic [7:0] UXC_EP_CTRL    = 8'h00;
    localparam logic [7:0] UXC_EP_IN_FLAG = 8'h80;
    // ****************************************************************
    // controller registers on wishbone (byte addresses)
    // ****************************************************************
    localparam logic [7:0] UXC_WB_CTRL_OFS = 8'h00;
    localparam logic [7:0] UXC_WB_CMD_OFS  = 8'h04;
    localparam logic [7:0] UXC_WB_STAT_OFS = 8'h08;
    typedef enum logic [1:0] {UXC_TST_NORMAL, UXC_TST_DIFF1, UXC_TST_DIFF0, UXC_TST_SE0} uxc_tst_t;
    typedef enum logic [1:0] {UXC_OP_CORE_WR, UXC_OP_CORE_RD, UXC_OP_SFR_WR, UXC_OP_SFR_RD} uxc_op_t;
endpackage

/* File: verilog/uxc_sfr_if.sv */
// special function register link between the controller and the usb block
`timescale 1ns/1ps
interface uxc_sfr_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr;
    logic       rd;
    logic       ack;
    logic       clk_active;
    modport dev  (input addr, wdata, wr, rd, clk_active, output rdata, ack);
    modport host (output addr, wdata, wr, rd, clk_active, input rdata, ack);
endinterface

/* File: verilog/uxc_core_bank.sv */
// core register bank reached through the indirect address and data pair
`timescale 1ns/1ps
module uxc_core_bank import uxc_pkg::*; #(
    parameter int NUM_EP = 4
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [5:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    output logic      [3:0] ep_select
);
    localparam int EPW = (NUM_EP > 1) ? $clog2(NUM_EP) : 1;
    generate
        if (NUM_EP < 1 || NUM_EP > 16 || (NUM_EP & (NUM_EP - 1)) != 0) begin : g_chk
            $error("uxc_core_bank: NUM_EP must be a power of two up to 16");
        end
    endgenerate

    logic [7:0] common_mem [64];
    logic [7:0] ep_mem     [NUM_EP][8];
    logic [3:0] index_reg;
    logic       is_indexed;
    logic       ep_valid;

    assign is_indexed = (addr >= UXC_IDX_LO) && (addr <= UXC_IDX_HI);
    assign ep_valid   = ({28'h000_0000, index_reg} < NUM_EP);
    assign ep_select  = index_reg;

    // endpoint index: upper bits never stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            index_reg <= UXC_INDEX_RST;
        end else if (wr_en && addr == UXC_INDEX_ADDR) begin
            index_reg <= wdata[3:0];
        end
    end

    // storage writes; reserved endpoints take no indexed write
    always_ff @(posedge clk) begin
        if (wr_en && addr != UXC_INDEX_ADDR) begin
            if (is_indexed) begin
                if (ep_valid) begin
                    ep_mem[index_reg[EPW-1:0]][addr[2:0]] <= wdata;
                end
            end else begin
                common_mem[addr] <= wdata;
            end
        end
    end

    // registered read of the addressed register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= UXC_DAT_RST;
        end else if (addr == UXC_INDEX_ADDR) begin
            rdata <= {4'h0, index_reg};
        end else if (is_indexed) begin
            rdata <= ep_valid ? ep_mem[index_reg[EPW-1:0]][addr[2:0]] : 8'h00;
        end else begin
            rdata <= common_mem[addr];
        end
    end
endmodule // uxc_core_bank

/* File: verilog/uxc_dev.sv */
// usb function block end: transceiver control and indirect register access
// How it works
// - control endpoint answers address 0x00 both ways
// - endpoints 1-3: IN 0x81-0x83, OUT 0x01-0x03
// - speed one: full speed, pull-up on D+
// - speed zero: low speed, pull-up on D-
// - pull-up only when enabled and VBUS present
// - phy enable zero suspends the transceiver
// - test field forces D+/D- line states while phy enabled
// - read-only differential receiver bit while enabled
// - read-only D+ and D- level bits
// - software starts usb clock before phy enable
// - data register targets held indirect address
// - software sets endpoint index before indexed access
// - usb clock must run during indirect access
// - busy write one starts read; zero ignored
// - busy reads one until data ready
// - software checks busy clear before data write
// - auto-read restarts read on each data read made while busy is clear
// - address register: six-bit address, auto, busy
// - write: poll busy, load address, write data
// - read: poll, address plus busy, poll, read
// - endpoint select 0-3 valid, higher reserved
// - index upper bits read zero, writes ignored
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module uxc_dev import uxc_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst_n,
    uxc_sfr_if.dev          bus,
    input  wire logic       vbus_present,
    input  wire logic       dp_in,
    input  wire logic       dn_in,
    output logic            dp_out,
    output logic            dp_oe_n,
    output logic            dn_out,
    output logic            dn_oe_n,
    output logic            pullup_dp,
    output logic            pullup_dn,
    output logic            phy_active,
    output logic            full_speed,
    input  wire logic       tok_valid,
    input  wire logic [7:0] tok_ep_addr,
    input  wire logic       tok_dir_in,
    output logic            ep_hit,
    output logic      [1:0] ep_num,
    output logic            ep_is_in,
    output logic      [3:0] ep_select
);
    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:3] xcvr_ctrl_reg;
    logic       diff_state_reg;
    logic       positive_line_level_reg;
    logic       negative_line_level_reg;
    logic [5:0] indirect_target_address_reg;
    logic       auto_read_enable_reg;
    logic       busy_reg;
    logic [1:0] rd_cnt_reg;
    logic [7:0] indirect_data_reg;
    logic [7:0] rdata_reg;
    logic       ack_reg;
    logic [7:0] bank_rdata;
    logic       wr_xcvr;
    logic       wr_adr;
    logic       wr_dat;
    logic       rd_dat;
    logic       bank_wr;
    logic       start_rd;
    logic       pullup_enable;
    logic       phy_enable;
    logic       speed_full;
    uxc_tst_t   phy_test_mode;

    assign wr_xcvr       = bus.wr && bus.addr == UXC_XCVR_OFS;
    assign wr_adr        = bus.wr && bus.addr == UXC_ADR_OFS;
    assign wr_dat        = bus.wr && bus.addr == UXC_DAT_OFS;
    assign rd_dat        = bus.rd && bus.addr == UXC_DAT_OFS;
    assign pullup_enable = xcvr_ctrl_reg[UXC_PULLUP_ENABLE_BIT];
    assign phy_enable    = xcvr_ctrl_reg[UXC_PHY_ENABLE_BIT];
    assign speed_full    = xcvr_ctrl_reg[UXC_SPEED_BIT];
    assign phy_test_mode = uxc_tst_t'(xcvr_ctrl_reg[UXC_TST_HI_BIT:UXC_TST_LO_BIT]);

    // data writes land in the held core address when idle and clocked
    assign bank_wr  = wr_dat && !busy_reg && bus.clk_active;
    // explicit busy write, or a data read with auto-read set while busy is clear
    assign start_rd = (wr_adr && bus.wdata[UXC_BUSY_BIT])
                    || (rd_dat && auto_read_enable_reg && !busy_reg);

    uxc_core_bank #(
        .NUM_EP (4)
    ) u_bank (
        .clk       (clk),
        .rst_n     (rst_n),
        .wr_en     (bank_wr),
        .addr      (indirect_target_address_reg),
        .wdata     (bus.wdata),
        .rdata     (bank_rdata),
        .ep_select (ep_select)
    );

    // ****************************************************************
    // transceiver control register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xcvr_ctrl_reg <= UXC_XCVR_RST[7:3];
        end else if (wr_xcvr) begin
            xcvr_ctrl_reg <= bus.wdata[7:3];
        end
    end

    // line status sampling; receiver bit only meaningful while enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            diff_state_reg          <= 1'b0;
            positive_line_level_reg <= 1'b0;
            negative_line_level_reg <= 1'b0;
        end else begin
            diff_state_reg          <= phy_enable && dp_in && !dn_in;
            positive_line_level_reg <= dp_in;
            negative_line_level_reg <= dn_in;
        end
    end

    // pull-up placement and phy state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pullup_dp  <= 1'b0;
            pullup_dn  <= 1'b0;
            phy_active <= 1'b0;
            full_speed <= 1'b0;
        end else begin
            pullup_dp  <= pullup_enable && vbus_present && speed_full;
            pullup_dn  <= pullup_enable && vbus_present && !speed_full;
            phy_active <= phy_enable;
            full_speed <= speed_full;
        end
    end

    // forced line states while the transceiver is enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dp_out  <= 1'b0;
            dn_out  <= 1'b0;
            dp_oe_n <= 1'b1;
            dn_oe_n <= 1'b1;
        end else begin
            dp_oe_n <= !(phy_enable && phy_test_mode != UXC_TST_NORMAL);
            dn_oe_n <= !(phy_enable && phy_test_mode != UXC_TST_NORMAL);
            unique case (phy_test_mode)
                UXC_TST_NORMAL: begin
                    dp_out <= 1'b0;
                    dn_out <= 1'b0;
                end
                UXC_TST_DIFF1: begin
                    dp_out <= 1'b1;
                    dn_out <= 1'b0;
                end
                UXC_TST_DIFF0: begin
                    dp_out <= 1'b0;
                    dn_out <= 1'b1;
                end
                UXC_TST_SE0: begin
                    dp_out <= 1'b0;
                    dn_out <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // indirect access
    // ****************************************************************
    // address and auto-read fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            indirect_target_address_reg <= UXC_ADDR_RST;
            auto_read_enable_reg        <= 1'b0;
        end else if (wr_adr) begin
            indirect_target_address_reg <= bus.wdata[5:0];
            auto_read_enable_reg        <= bus.wdata[UXC_AUTO_BIT];
        end
    end

    // busy and read pipeline; a new start wins over completion
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_reg   <= 1'b0;
            rd_cnt_reg <= 2'h0;
        end else if (start_rd) begin
            busy_reg   <= 1'b1;
            rd_cnt_reg <= UXC_READ_LAT;
        end else if (busy_reg && bus.clk_active) begin
            rd_cnt_reg <= rd_cnt_reg - 2'h1;
            if (rd_cnt_reg == 2'h1) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // data holding register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            indirect_data_reg <= UXC_DAT_RST;
        end else if (busy_reg && bus.clk_active && rd_cnt_reg == 2'h1 && !start_rd) begin
            indirect_data_reg <= bank_rdata;
        end else if (bank_wr) begin
            indirect_data_reg <= bus.wdata;
        end
    end

    // ****************************************************************
    // link answers: one-cycle acknowledge, registered read data
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ack_reg <= bus.wr || bus.rd;
            if (bus.rd) begin
                unique case (bus.addr)
                    UXC_XCVR_OFS: rdata_reg <= {xcvr_ctrl_reg, diff_state_reg,
                                  positive_line_level_reg, negative_line_level_reg};
                    UXC_ADR_OFS:  rdata_reg <= {busy_reg, auto_read_enable_reg,
                                  indirect_target_address_reg};
                    UXC_DAT_OFS:  rdata_reg <= indirect_data_reg;
                    default:      rdata_reg <= 8'h00;
                endcase
            end
        end
    end
    assign bus.ack   = ack_reg;
    assign bus.rdata = rdata_reg;

    // ****************************************************************
    // token endpoint decode
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ep_hit   <= 1'b0;
            ep_num   <= 2'h0;
            ep_is_in <= 1'b0;
        end else if (!tok_valid) begin
            ep_hit <= 1'b0;
        end else if (tok_ep_addr == UXC_EP_CTRL) begin
            ep_hit   <= 1'b1;
            ep_num   <= 2'h0;
            ep_is_in <= tok_dir_in;
        end else begin
            ep_hit   <= (tok_ep_addr[6:2] == 5'h00) && (tok_ep_addr[1:0] != 2'h0);
            ep_num   <= tok_ep_addr[1:0];
            ep_is_in <= (tok_ep_addr & UXC_EP_IN_FLAG) != 8'h00;
        end
    end
endmodule // uxc_dev

/* File: verilog/uxc_host.sv */
// controller end: runs indirect access sequences ordered over wishbone
`timescale 1ns/1ps
module uxc_host import uxc_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    uxc_sfr_if.host          bus
);
    typedef enum {H_IDLE, H_ISSUE, H_WAIT} uxc_hstate_t;
    typedef enum {S_POLL0, S_IDX_ADR, S_IDX_DAT, S_TGT_ADR, S_TGT_DAT,
                  S_POLL2, S_READ, S_RAW} uxc_step_t;

    uxc_hstate_t state_reg;
    uxc_step_t   step_reg;
    uxc_op_t     op_reg;
    logic [7:0]  data_reg;
    logic [7:0]  addr_reg;
    logic [1:0]  ep_reg;
    logic [7:0]  result_reg;
    logic        clk_on_reg;
    logic        refused_reg;
    logic        wr_reg;
    logic        rd_reg;
    logic [7:0]  sfr_addr_reg;
    logic [7:0]  sfr_wdata_reg;
    logic        wb_write;
    logic        cmd_go;
    logic        cmd_bad;
    logic        indexed;
    logic        is_read;
    logic        busy_seen;
    logic [7:0]  step_addr;
    logic [7:0]  step_wdata;
    logic        step_wr;

    // write takes effect at the edge that samples ack
    assign wb_write  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign cmd_go    = wb_write && wb_adr_i == UXC_WB_CMD_OFS && wb_sel_i == 4'hf;
    // sequencer busy, core access without usb clock, or phy enable before clock runs
    assign cmd_bad   = (state_reg != H_IDLE) || (!clk_on_reg && (wb_dat_i[25] == 1'b0
                     || (wb_dat_i[15:8] == UXC_XCVR_OFS && wb_dat_i[24] == 1'b0
                         && wb_dat_i[UXC_PHY_ENABLE_BIT])));
    assign indexed   = addr_reg[5:0] >= UXC_IDX_LO && addr_reg[5:0] <= UXC_IDX_HI;
    assign is_read   = op_reg == UXC_OP_CORE_RD;
    assign busy_seen = bus.rdata[UXC_BUSY_BIT];

    // per-step link access
    always_comb begin
        step_addr  = UXC_ADR_OFS;
        step_wdata = 8'h00;
        step_wr    = 1'b0;
        unique case (step_reg)
            S_POLL0, S_POLL2: step_addr = UXC_ADR_OFS;
            S_IDX_ADR: begin
                step_wdata = {2'b00, UXC_INDEX_ADDR};
                step_wr    = 1'b1;
            end
            S_IDX_DAT: begin
                step_addr  = UXC_DAT_OFS;
                step_wdata = {6'h00, ep_reg};
                step_wr    = 1'b1;
            end
            S_TGT_ADR: begin
                step_wdata = {is_read, 1'b0, addr_reg[5:0]};
                step_wr    = 1'b1;
            end
            S_TGT_DAT: begin
                step_addr  = UXC_DAT_OFS;
                step_wdata = data_reg;
                step_wr    = 1'b1;
            end
            S_READ: step_addr = UXC_DAT_OFS;
            S_RAW: begin
                step_addr  = addr_reg;
                step_wdata = data_reg;
                step_wr    = op_reg == UXC_OP_SFR_WR;
            end
        endcase
    end

    // sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg     <= H_IDLE;
            step_reg      <= S_POLL0;
            wr_reg        <= 1'b0;
            rd_reg        <= 1'b0;
            sfr_addr_reg  <= 8'h00;
            sfr_wdata_reg <= 8'h00;
        end else begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            unique case (state_reg)
                H_IDLE: if (cmd_go && !cmd_bad) begin
                    state_reg <= H_ISSUE;
                    step_reg  <= wb_dat_i[25] ? S_RAW : S_POLL0;
                end
                H_ISSUE: begin
                    wr_reg        <= step_wr;
                    rd_reg        <= !step_wr;
                    sfr_addr_reg  <= step_addr;
                    sfr_wdata_reg <= step_wdata;
                    state_reg     <= H_WAIT;
                end
                H_WAIT: if (bus.ack) begin
                    state_reg <= H_ISSUE;
                    unique case (step_reg)
                        S_POLL0:   step_reg <= busy_seen ? S_POLL0
                                             : (indexed ? S_IDX_ADR : S_TGT_ADR);
                        S_IDX_ADR: step_reg <= S_IDX_DAT;
                        S_IDX_DAT: step_reg <= S_TGT_ADR;
                        S_TGT_ADR: step_reg <= is_read ? S_POLL2 : S_TGT_DAT;
                        S_POLL2:   step_reg <= busy_seen ? S_POLL2 : S_READ;
                        S_TGT_DAT, S_READ, S_RAW: state_reg <= H_IDLE;
                    endcase
                end
            endcase
        end
    end

    // command, result and control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_reg      <= UXC_OP_CORE_WR;
            data_reg    <= 8'h00;
            addr_reg    <= 8'h00;
            ep_reg      <= 2'h0;
            result_reg  <= 8'h00;
            clk_on_reg  <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            if (wb_write && wb_adr_i == UXC_WB_CTRL_OFS && wb_sel_i[0]) begin
                clk_on_reg <= wb_dat_i[0];
            end
            if (cmd_go) begin
                refused_reg <= cmd_bad;
                if (!cmd_bad) begin
                    data_reg <= wb_dat_i[7:0];
                    addr_reg <= wb_dat_i[15:8];
                    ep_reg   <= wb_dat_i[17:16];
                    op_reg   <= uxc_op_t'(wb_dat_i[25:24]);
                end
            end
            if (state_reg == H_WAIT && bus.ack && rd_reg == 1'b0
                && (step_reg == S_READ || (step_reg == S_RAW && op_reg == UXC_OP_SFR_RD))) begin
                result_reg <= bus.rdata;
            end
        end
    end

    // wishbone answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            unique case (wb_adr_i)
                UXC_WB_CTRL_OFS: wb_dat_o <= {31'h0000_0000, clk_on_reg};
                UXC_WB_CMD_OFS:  wb_dat_o <= {6'h00, op_reg, 6'h00, ep_reg, addr_reg, data_reg};
                UXC_WB_STAT_OFS: wb_dat_o <= {16'h0000, result_reg, 6'h00, refused_reg,
                                              state_reg != H_IDLE};
                default:         wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    assign bus.wr         = wr_reg;
    assign bus.rd         = rd_reg;
    assign bus.addr       = sfr_addr_reg;
    assign bus.wdata      = sfr_wdata_reg;
    assign bus.clk_active = clk_on_reg;
endmodule // uxc_host

/* File: bench/uxc_assertions.sv */
// link checker for the usb transceiver control register link
`timescale 1ns/1ps
module uxc_assertions import uxc_pkg::*; (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       ack,
    input wire logic       clk_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] adr_reg;
    logic [7:0] xc_reg;
    // shadow of the last address byte written
    always_ff @(posedge clk) begin
        if (!rst_n) adr_reg <= 8'h00;
        else if (wr && addr == UXC_ADR_OFS) adr_reg <= wdata;
    end
    // shadow of the last transceiver byte written
    always_ff @(posedge clk) begin
        if (!rst_n) xc_reg <= 8'h00;
        else if (wr && addr == UXC_XCVR_OFS) xc_reg <= wdata;
    end
    // ***********
    // link checks
    // ***********
    a_req_acked: assert property ((wr || rd) |=> ack) else $error("no ack");
    a_ack_caused: assert property (ack |-> $past(wr || rd)) else $error("stray ack");
    a_rdata_hold: assert property (!$past(rd) |-> $stable(rdata)) else $error("rdata moved");
    a_addr_readback: assert property (rd && addr == UXC_ADR_OFS |=>
        rdata[5:0] == adr_reg[5:0]) else $error("address lost");
    a_auto_kept: assert property (rd && addr == UXC_ADR_OFS |=>
        rdata[6] == adr_reg[6]) else $error("auto bit lost");
    a_speed_readback: assert property (rd && addr == UXC_XCVR_OFS |=>
        rdata[7:5] == xc_reg[7:5]) else $error("control bits lost");
    a_test_readback: assert property (rd && addr == UXC_XCVR_OFS |=>
        rdata[4:3] == xc_reg[4:3]) else $error("test field lost");
    a_phy_clock: assert property (wr && addr == UXC_XCVR_OFS && wdata[6] |->
        clk_active) else $error("phy on without clock");
    c_busy_start: cover property (wr && addr == UXC_ADR_OFS && wdata[UXC_BUSY_BIT]);
    c_data_read: cover property (rd && addr == UXC_DAT_OFS);
    c_data_write: cover property (wr && addr == UXC_DAT_OFS);
endmodule // uxc_assertions

/* File: bench/test_usb_xcvr_ctrl_indirect_access.sv */
// self-checking bench for the usb transceiver control link
`timescale 1ns/1ps
module test_usb_xcvr_ctrl_indirect_access import uxc_pkg::*; ;
    logic clk = 0, rst_n = 0, cyc = 0, we = 0, vbus = 1, dp = 1, dn = 0, tv = 0, tin = 0;
    logic ack, po, pd, pon, pdn, pu_p, pu_n, act, fs, hit, isin;
    logic [7:0]  adr = 0, ta = 0;
    logic [31:0] wd = 0, rdat, s;
    logic [1:0]  num;
    logic [3:0]  sel_ep;
    logic [11:0] tok [6] = '{12'h009, 12'h008, 12'h82d, 12'h01a, 12'h83f, 12'h840};
    int errors = 0, num_checks = 0;
    uxc_sfr_if sfr ();
    // free running clock
    always #20 clk = ~clk;
    uxc_host uxc_host_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .bus(sfr));
    uxc_dev uxc_dev_i (.clk(clk), .rst_n(rst_n), .bus(sfr), .vbus_present(vbus), .dp_in(dp),
        .dn_in(dn), .dp_out(po), .dp_oe_n(pon), .dn_out(pd), .dn_oe_n(pdn), .pullup_dp(pu_p),
        .pullup_dn(pu_n), .phy_active(act), .full_speed(fs), .tok_valid(tv), .tok_ep_addr(ta),
        .tok_dir_in(tin), .ep_hit(hit), .ep_num(num), .ep_is_in(isin), .ep_select(sel_ep));
    uxc_assertions uxc_assertions_i (.clk(clk), .rst_n(rst_n), .addr(sfr.addr), .wdata(sfr.wdata),
        .rdata(sfr.rdata), .wr(sfr.wr), .rd(sfr.rd), .ack(sfr.ack), .clk_active(sfr.clk_active));
    // *****
    // tasks
    // *****
    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    // one classic wishbone cycle, read data kept in s
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        s = rdat;
        cyc <= 0;
    endtask
    // issue a command and poll until the sequencer is idle
    task automatic cmd(input logic [1:0] op, ep, input logic [7:0] a, d);
        wb(1, UXC_WB_CMD_OFS, {6'h0, op, 6'h0, ep, a, d});
        do wb(0, UXC_WB_STAT_OFS, 0); while (s[0] !== 1'b0);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        chk({pon, pdn, pu_p, pu_n, act}, 5'b11000);
        wb(0, 8'h0c, 0);
        chk(s, 0);
        wb(1, UXC_WB_CTRL_OFS, 1);
        cmd(2, 0, UXC_XCVR_OFS, 8'he0);
        chk({pu_p, pu_n, fs, act}, 4'b1011);
        cmd(3, 0, UXC_XCVR_OFS, 0);
        chk(s[15:8], 8'he6);
        cmd(2, 0, UXC_XCVR_OFS, 8'h80);
        chk({pu_p, pu_n, fs, act}, 4'b0100);
        vbus <= 0;
        cmd(3, 0, UXC_XCVR_OFS, 0);
        chk({pu_n, s[10:8]}, 4'b0010);
        for (int m = 0; m < 4; m++) begin
            cmd(2, 0, UXC_XCVR_OFS, 8'h40 | 8'(m << 3));
            chk({pon, pdn, (m != 0) ? {po, pd} : 2'b00}, {m == 0, m == 0, m == 1, m == 2});
        end
        // line levels swapped while the phy is on
        dp <= 0;
        dn <= 1;
        cmd(3, 0, UXC_XCVR_OFS, 0);
        chk(s[15:8], 8'h59);
        cmd(0, 0, 8'h05, 8'h5a);
        cmd(1, 0, 8'h05, 0);
        chk(s[15:8], 8'h5a);
        // auto-read: first data read returns old byte and fetches the next
        cmd(0, 0, 8'h06, 8'ha5);
        cmd(2, 0, UXC_ADR_OFS, 8'h45);
        cmd(3, 0, UXC_DAT_OFS, 0);
        chk(s[15:8], 8'ha5);
        cmd(3, 0, UXC_DAT_OFS, 0);
        chk(s[15:8], 8'h5a);
        cmd(0, 0, 8'h0f, 8'hf1);
        cmd(1, 0, 8'h0f, 0);
        chk({s[15:8], sel_ep}, 12'h011);
        cmd(0, 2, UXC_IDX_LO, 8'h33);
        chk(sel_ep, 2);
        wb(1, UXC_WB_CTRL_OFS, 0);
        cmd(0, 0, 8'h05, 8'h11);
        chk(s[1:0], 2'b10);
        cmd(2, 0, UXC_XCVR_OFS, 8'h40);
        chk(s[1:0], 2'b10);
        // busy stalls while the usb clock is off
        cmd(2, 0, UXC_ADR_OFS, 8'h85);
        cmd(3, 0, UXC_ADR_OFS, 0);
        chk(s[15:8], 8'h85);
        wb(1, UXC_WB_CTRL_OFS, 1);
        cmd(3, 0, UXC_ADR_OFS, 0);
        chk(s[15:8], 8'h05);
        foreach (tok[i]) begin
            ta <= tok[i][11:4];
            tin <= tok[i][0];
            tv <= 1;
            repeat (2) @(posedge clk);
            chk({hit, hit ? {num, isin} : 3'b000}, tok[i][3:0]);
        end
        test_done;
    end
endmodule // test_usb_xcvr_ctrl_indirect_access
